// file: rtl/psesx_pkg.sv
/*
 Package for the processor status word block: bit positions, field
 widths, level and exception encodings, AXI4-Lite register offsets.
 Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package psesx_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTX_PTR = 8'h04;
   localparam logic [7:0] OFS_EVENT = 8'h08;
   localparam logic [7:0] OFS_CTRL_OUT = 8'h0c;
   // status word field positions
   localparam int B_FLUSH_INH = 25;
   localparam int B_FAST_INT = 24;
   localparam int B_CACHE_OFF = 23;
   localparam int B_OVF_TRAP = 22;
   localparam int B_FLAGS_HI = 21;
   localparam int B_FLAGS_LO = 18;
   localparam int B_STEP = 17;
   localparam int B_IML_HI = 16;
   localparam int B_IML_LO = 13;
   localparam int B_CUR_HI = 12;
   localparam int B_CUR_LO = 11;
   localparam int B_PRI_HI = 10;
   localparam int B_PRI_LO = 9;
   localparam int B_SAVE_REGS = 8;
   localparam int B_INIT_CTX = 7;
   localparam int B_SUB_HI = 6;
   localparam int B_SUB_LO = 3;
   localparam int B_TRACE_SUP = 2;
   localparam int B_CLS_HI = 1;
   localparam int B_CLS_LO = 0;
   // bits software may write (excludes 31..26, bit 08 and bit 02)
   localparam logic [31:0] WR_MASK = 32'h03fffefb;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;
   localparam logic [3:0] IML_NONE = 4'h0;
   localparam logic [3:0] IML_ALL = 4'hf;

   typedef enum logic [1:0]
   {
      LVL_KERNEL = 2'b00,
      LVL_EXEC = 2'b01,
      LVL_SUPER = 2'b10,
      LVL_USER = 2'b11
   } psesx_level_t;

   typedef enum logic [1:0]
   {
      CLS_RESET = 2'b00,
      CLS_PROCESS = 2'b01,
      CLS_STACK = 2'b10,
      CLS_NORMAL = 2'b11
   } psesx_class_t;

   // normal class
   localparam logic [3:0] N_ZERO_DIV = 4'h0;
   localparam logic [3:0] N_TRACE = 4'h1;
   localparam logic [3:0] N_ILL_OP = 4'h2;
   localparam logic [3:0] N_RSV_OP = 4'h3;
   localparam logic [3:0] N_INV_DESC = 4'h4;
   localparam logic [3:0] N_EXT_MEM = 4'h5;
   localparam logic [3:0] N_GATE_VEC = 4'h6;
   localparam logic [3:0] N_ILL_LVL = 4'h7;
   localparam logic [3:0] N_RSV_DT = 4'h8;
   localparam logic [3:0] N_INT_OVF = 4'h9;
   localparam logic [3:0] N_PRIV_OP = 4'ha;
   localparam logic [3:0] N_BREAK = 4'hb;
   localparam logic [3:0] N_PRIV_REG = 4'hf;
   // stack class
   localparam logic [3:0] S_BOUND = 4'h0;
   localparam logic [3:0] S_FAULT = 4'h1;
   localparam logic [3:0] S_INT_ID = 4'h2;
   // process class
   localparam logic [3:0] P_OLD_CTX = 4'h0;
   localparam logic [3:0] P_GATE_CTX = 4'h1;
   localparam logic [3:0] P_NEW_CTX = 4'h4;
   // reset class
   localparam logic [3:0] R_OLD_CTX = 4'h0;
   localparam logic [3:0] R_SYS_DATA = 4'h1;
   localparam logic [3:0] R_INT_STACK = 4'h2;
   localparam logic [3:0] R_EXT_RESET = 4'h3;
   localparam logic [3:0] R_NEW_CTX = 4'h4;
   localparam logic [3:0] R_GATE_VEC = 4'h6;

   localparam int N_NORMAL = 13;
   localparam int N_OTHER = 12;

   // condition flags from the execute unit
   typedef struct packed
   {
      logic negative;
      logic zero;
      logic overflow;
      logic carry;
   } psesx_flags_t;

   // one exception report: class and subcode
   typedef struct packed
   {
      logic valid;
      psesx_class_t cls;
      logic [3:0] sub;
   } psesx_exc_t;

   // indexes of the 12 non-normal event inputs
   typedef enum logic [3:0]
   {
      EV_STK_BOUND = 4'h0,
      EV_STK_FAULT = 4'h1,
      EV_STK_INT_ID = 4'h2,
      EV_P_OLD = 4'h3,
      EV_P_GATE = 4'h4,
      EV_P_NEW = 4'h5,
      EV_R_OLD = 4'h6,
      EV_R_SYS = 4'h7,
      EV_R_ISTK = 4'h8,
      EV_R_EXT = 4'h9,
      EV_R_NEW = 4'ha,
      EV_R_GATE = 4'hb
   } psesx_event_t;
endpackage

// file: rtl/psesx_status.sv
/*
 Processor status word register with exception classification, level
 tracking, interrupt admission and context-block pointer, reachable
 over AXI4-Lite. Assumes the execute unit and sequencer drive the
 event inputs for one cycle each and that the bus master is a
 well-behaved AXI4-Lite master.
*/
`timescale 1ns/10ps
module psesx_status
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   // AXI4-Lite slave
   input wire logic [psesx_pkg::ADDR_W-1:0] S_AWADDR,
   input wire logic S_AWVALID,
   output logic S_AWREADY,
   input wire logic [31:0] S_WDATA,
   input wire logic [3:0] S_WSTRB,
   input wire logic S_WVALID,
   output logic S_WREADY,
   output logic [1:0] S_BRESP,
   output logic S_BVALID,
   input wire logic S_BREADY,
   input wire logic [psesx_pkg::ADDR_W-1:0] S_ARADDR,
   input wire logic S_ARVALID,
   output logic S_ARREADY,
   output logic [31:0] S_RDATA,
   output logic [1:0] S_RRESP,
   output logic S_RVALID,
   input wire logic S_RREADY,
   // execute unit and sequencer
   input wire logic INSN_START,
   input wire logic INSN_DONE,
   input wire psesx_pkg::psesx_flags_t FLAGS_IN,
   input wire logic OVF_DETECT,
   input wire logic [psesx_pkg::N_NORMAL-1:0] NORMAL_EVENTS,
   input wire logic [psesx_pkg::N_OTHER-1:0] OTHER_EVENTS,
   input wire logic CONTEXT_SWITCH,
   input wire logic GATE_RETURN,
   input wire logic PROCESS_LOAD,
   input wire logic SAVE_REGS_IN,
   input wire logic SAVE_REGS_LOAD,
   input wire logic [1:0] NEW_LEVEL,
   input wire logic LEVEL_CHANGE,
   input wire logic [3:0] INT_PRIORITY,
   input wire logic INT_REQ,
   input wire logic INT_NMI,
   // status-driven control outputs
   output logic CACHE_FLUSH,
   output logic CACHE_BYPASS,
   output logic FAST_INT_PATH,
   output logic INT_ACCEPT,
   output logic TRACE_TRAP,
   output logic OVF_TRAP,
   output logic SAVE_REGS,
   output logic START_INITIAL,
   output psesx_pkg::psesx_exc_t EXC_OUT,
   output logic [31:0] STATUS_WORD
);

logic [31:0] status;
logic [31:0] ctx_ptr;
logic [31:0] next_status;
logic aw_held;
logic w_held;
logic [psesx_pkg::ADDR_W-1:0] aw_addr;
logic [31:0] w_data;
logic [3:0] w_strb;
logic wr_fire;
logic wr_priv_fail;
logic [31:0] strb_mask;
logic [3:0] normal_sub;
logic normal_any;
logic [3:0] other_sub;
logic [1:0] other_cls;
logic other_any;
logic stack_any;
logic flag_reset;
logic tracing;
logic is_kernel;

////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path

assign wr_fire = aw_held && w_held && !S_BVALID;
assign is_kernel = status[psesx_pkg::B_CUR_HI:psesx_pkg::B_CUR_LO]
   == psesx_pkg::LVL_KERNEL;
assign wr_priv_fail = wr_fire && !is_kernel &&
   (aw_addr == psesx_pkg::OFS_STATUS || aw_addr == psesx_pkg::OFS_CTX_PTR);

always_ff @(posedge SYS_CLK or posedge RESET)
begin
   if (RESET)
   begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AWREADY <= 1'b0;
      S_WREADY <= 1'b0;
      S_BVALID <= 1'b0;
      S_BRESP <= 2'h0;
   end
   else
   begin
      S_AWREADY <= !aw_held && !(S_AWVALID && S_AWREADY);
      S_WREADY <= !w_held && !(S_WVALID && S_WREADY);
      if (S_AWVALID && S_AWREADY)
      begin
         aw_held <= 1'b1;
         aw_addr <= S_AWADDR;
      end
      if (S_WVALID && S_WREADY)
      begin
         w_held <= 1'b1;
         w_data <= S_WDATA;
         w_strb <= S_WSTRB;
      end
      if (wr_fire)
      begin
         S_BVALID <= 1'b1;
         // unmapped and privilege-refused writes answer SLVERR
         if (wr_priv_fail || aw_addr > psesx_pkg::OFS_CTRL_OUT ||
             aw_addr[1:0] != 2'h0)
            S_BRESP <= 2'h2;
         else
            S_BRESP <= 2'h0;
      end
      if (S_BVALID && S_BREADY)
      begin
         S_BVALID <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         S_AWREADY <= 1'b1;
         S_WREADY <= 1'b1;
      end
   end
end

genvar gi;
generate
   for (gi = 0; gi < 4; gi++)
   begin : g_strb
      assign strb_mask[gi*8 +: 8] = {8{w_strb[gi]}};
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// exception priority: lowest normal subcode index wins

always_comb
begin
   normal_any = |NORMAL_EVENTS;
   normal_sub = psesx_pkg::N_ZERO_DIV;
   for (int i = psesx_pkg::N_NORMAL - 1; i >= 0; i--)
   begin
      if (NORMAL_EVENTS[i])
      begin
         case (i)
            0: normal_sub = psesx_pkg::N_ZERO_DIV;
            1: normal_sub = psesx_pkg::N_TRACE;
            2: normal_sub = psesx_pkg::N_ILL_OP;
            3: normal_sub = psesx_pkg::N_RSV_OP;
            4: normal_sub = psesx_pkg::N_INV_DESC;
            5: normal_sub = psesx_pkg::N_EXT_MEM;
            6: normal_sub = psesx_pkg::N_GATE_VEC;
            7: normal_sub = psesx_pkg::N_ILL_LVL;
            8: normal_sub = psesx_pkg::N_RSV_DT;
            9: normal_sub = psesx_pkg::N_INT_OVF;
            10: normal_sub = psesx_pkg::N_PRIV_OP;
            11: normal_sub = psesx_pkg::N_BREAK;
            default: normal_sub = psesx_pkg::N_PRIV_REG;
         endcase
      end
   end
end

// reset class outranks process, which outranks stack
always_comb
begin
   other_any = |OTHER_EVENTS;
   other_sub = psesx_pkg::S_BOUND;
   other_cls = psesx_pkg::CLS_STACK;
   for (int i = 0; i < psesx_pkg::N_OTHER; i++)
   begin
      if (OTHER_EVENTS[i])
      begin
         case (i)
            0:
            begin
               other_cls = psesx_pkg::CLS_STACK;
               other_sub = psesx_pkg::S_BOUND;
            end
            1:
            begin
               other_cls = psesx_pkg::CLS_STACK;
               other_sub = psesx_pkg::S_FAULT;
            end
            2:
            begin
               other_cls = psesx_pkg::CLS_STACK;
               other_sub = psesx_pkg::S_INT_ID;
            end
            3:
            begin
               other_cls = psesx_pkg::CLS_PROCESS;
               other_sub = psesx_pkg::P_OLD_CTX;
            end
            4:
            begin
               other_cls = psesx_pkg::CLS_PROCESS;
               other_sub = psesx_pkg::P_GATE_CTX;
            end
            5:
            begin
               other_cls = psesx_pkg::CLS_PROCESS;
               other_sub = psesx_pkg::P_NEW_CTX;
            end
            6:
            begin
               other_cls = psesx_pkg::CLS_RESET;
               other_sub = psesx_pkg::R_OLD_CTX;
            end
            7:
            begin
               other_cls = psesx_pkg::CLS_RESET;
               other_sub = psesx_pkg::R_SYS_DATA;
            end
            8:
            begin
               other_cls = psesx_pkg::CLS_RESET;
               other_sub = psesx_pkg::R_INT_STACK;
            end
            9:
            begin
               other_cls = psesx_pkg::CLS_RESET;
               other_sub = psesx_pkg::R_EXT_RESET;
            end
            10:
            begin
               other_cls = psesx_pkg::CLS_RESET;
               other_sub = psesx_pkg::R_NEW_CTX;
            end
            default:
            begin
               other_cls = psesx_pkg::CLS_RESET;
               other_sub = psesx_pkg::R_GATE_VEC;
            end
         endcase
      end
   end
end

assign stack_any = |OTHER_EVENTS[2:0];
assign flag_reset = NORMAL_EVENTS[0] || NORMAL_EVENTS[4] ||
   NORMAL_EVENTS[8] || stack_any;

////////////////////////////////////////////////////////////////////////
// status word next value; hardware events applied after software write

always_comb
begin
   next_status = status;
   if (wr_fire && !wr_priv_fail && aw_addr == psesx_pkg::OFS_STATUS)
      next_status = (status & ~(psesx_pkg::WR_MASK & strb_mask)) |
         (w_data & psesx_pkg::WR_MASK & strb_mask);
   if (INSN_DONE)
      next_status[psesx_pkg::B_FLAGS_HI:psesx_pkg::B_FLAGS_LO] =
         FLAGS_IN;
   if (LEVEL_CHANGE)
   begin
      next_status[psesx_pkg::B_PRI_HI:psesx_pkg::B_PRI_LO] =
         status[psesx_pkg::B_CUR_HI:psesx_pkg::B_CUR_LO];
      next_status[psesx_pkg::B_CUR_HI:psesx_pkg::B_CUR_LO] =
         NEW_LEVEL;
   end
   if (SAVE_REGS_LOAD)
      next_status[psesx_pkg::B_SAVE_REGS] = SAVE_REGS_IN;
   if (INSN_START)
      next_status[psesx_pkg::B_TRACE_SUP] = 1'b1;
   if (CONTEXT_SWITCH || GATE_RETURN || normal_any || other_any ||
       wr_priv_fail || INT_ACCEPT)
      next_status[psesx_pkg::B_TRACE_SUP] = 1'b0;
   if (OVF_TRAP)
      next_status[psesx_pkg::B_OVF_TRAP] = 1'b0;
   if (other_any)
   begin
      next_status[psesx_pkg::B_CLS_HI:psesx_pkg::B_CLS_LO] = other_cls;
      next_status[psesx_pkg::B_SUB_HI:psesx_pkg::B_SUB_LO] = other_sub;
   end
   else if (normal_any || wr_priv_fail)
   begin
      next_status[psesx_pkg::B_CLS_HI:psesx_pkg::B_CLS_LO] =
         psesx_pkg::CLS_NORMAL;
      next_status[psesx_pkg::B_SUB_HI:psesx_pkg::B_SUB_LO] =
         normal_any ? normal_sub : psesx_pkg::N_PRIV_REG;
   end
   if (flag_reset)
      next_status[psesx_pkg::B_FLAGS_HI:psesx_pkg::B_FLAGS_LO] =
         4'h0;
   next_status[31:26] = 6'h00;
end

always_ff @(posedge SYS_CLK or posedge RESET)
begin
   if (RESET)
      status <= psesx_pkg::STATUS_RESET;
   else
      status <= next_status;
end

always_ff @(posedge SYS_CLK or posedge RESET)
begin
   if (RESET)
      ctx_ptr <= 32'h00000000;
   else if (wr_fire && !wr_priv_fail && aw_addr == psesx_pkg::OFS_CTX_PTR)
      ctx_ptr <= (ctx_ptr & ~strb_mask) | (w_data & strb_mask);
end

////////////////////////////////////////////////////////////////////////
// control outputs

// tracing armed only while not masked for the current instruction
assign tracing = status[psesx_pkg::B_STEP] &&
   !status[psesx_pkg::B_TRACE_SUP];

always_ff @(posedge SYS_CLK or posedge RESET)
begin
   if (RESET)
   begin
      CACHE_FLUSH <= 1'b0;
      CACHE_BYPASS <= 1'b0;
      FAST_INT_PATH <= 1'b0;
      INT_ACCEPT <= 1'b0;
      TRACE_TRAP <= 1'b0;
      OVF_TRAP <= 1'b0;
      SAVE_REGS <= 1'b0;
      START_INITIAL <= 1'b0;
      EXC_OUT <= '0;
      STATUS_WORD <= psesx_pkg::STATUS_RESET;
   end
   else
   begin
      CACHE_FLUSH <= PROCESS_LOAD && !status[psesx_pkg::B_FLUSH_INH];
      CACHE_BYPASS <= next_status[psesx_pkg::B_CACHE_OFF];
      FAST_INT_PATH <= next_status[psesx_pkg::B_FAST_INT];
      INT_ACCEPT <= INT_NMI || (INT_REQ && INT_PRIORITY >
         status[psesx_pkg::B_IML_HI:psesx_pkg::B_IML_LO]);
      TRACE_TRAP <= INSN_DONE && tracing;
      OVF_TRAP <= OVF_DETECT && status[psesx_pkg::B_OVF_TRAP] &&
         !OVF_TRAP;
      SAVE_REGS <= next_status[psesx_pkg::B_SAVE_REGS];
      START_INITIAL <= next_status[psesx_pkg::B_INIT_CTX];
      EXC_OUT.valid <= other_any || normal_any || wr_priv_fail;
      EXC_OUT.cls <= psesx_pkg::psesx_class_t'(
         next_status[psesx_pkg::B_CLS_HI:psesx_pkg::B_CLS_LO]);
      EXC_OUT.sub <= next_status[psesx_pkg::B_SUB_HI:psesx_pkg::B_SUB_LO];
      STATUS_WORD <= next_status;
   end
end

////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path

always_ff @(posedge SYS_CLK or posedge RESET)
begin
   if (RESET)
   begin
      S_ARREADY <= 1'b0;
      S_RVALID <= 1'b0;
      S_RDATA <= 32'h00000000;
      S_RRESP <= 2'h0;
   end
   else
   begin
      S_ARREADY <= !S_RVALID && !(S_ARVALID && S_ARREADY);
      if (S_ARVALID && S_ARREADY)
      begin
         S_RVALID <= 1'b1;
         S_RRESP <= 2'h0;
         case (S_ARADDR)
            psesx_pkg::OFS_STATUS: S_RDATA <= status;
            psesx_pkg::OFS_CTX_PTR: S_RDATA <= ctx_ptr;
            psesx_pkg::OFS_EVENT: S_RDATA <= {27'h0000000, OVF_TRAP,
               TRACE_TRAP, INT_ACCEPT, CACHE_FLUSH, EXC_OUT.valid};
            psesx_pkg::OFS_CTRL_OUT: S_RDATA <= {28'h0000000, START_INITIAL,
               SAVE_REGS, FAST_INT_PATH, CACHE_BYPASS};
            default:
            begin
               S_RDATA <= 32'h00000000;
               S_RRESP <= 2'h2;
            end
         endcase
      end
      else if (S_RVALID && S_RREADY)
      begin
         S_RVALID <= 1'b0;
         S_ARREADY <= 1'b1;
      end
   end
end

endmodule // psesx_status

// file: verification/psesx_status_monitor.sv
/*
 Checker for the status word block: timing relations at its ports.
 Assumes it is bound to psesx_status and sees only that module's ports.
*/
`timescale 1ns/10ps
module psesx_status_monitor
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic INSN_DONE,
   input wire psesx_pkg::psesx_flags_t FLAGS_IN,
   input wire logic OVF_DETECT,
   input wire logic PROCESS_LOAD,
   input wire logic [1:0] NEW_LEVEL,
   input wire logic LEVEL_CHANGE,
   input wire logic [3:0] INT_PRIORITY,
   input wire logic INT_REQ,
   input wire logic INT_NMI,
   input wire logic CACHE_FLUSH,
   input wire logic CACHE_BYPASS,
   input wire logic FAST_INT_PATH,
   input wire logic INT_ACCEPT,
   input wire logic TRACE_TRAP,
   input wire logic OVF_TRAP,
   input wire logic SAVE_REGS,
   input wire logic START_INITIAL,
   input wire logic [31:0] STATUS_WORD
);
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);
   ////////////////////////////////////////
   a_top_zero: assert property (STATUS_WORD[31:26] == 6'h00)
      else $error("top status bits not zero");
   a_flush_load: assert property (CACHE_FLUSH ==
      ($past(PROCESS_LOAD) && !$past(STATUS_WORD[25])))
      else $error("cache flush does not follow process load");
   a_ctrl_mirror: assert property (
      CACHE_BYPASS == STATUS_WORD[23] && FAST_INT_PATH == STATUS_WORD[24])
      else $error("cache or interrupt path control off its bit");
   a_ovf_trap: assert property (OVF_DETECT && STATUS_WORD[22] |=>
      OVF_TRAP ##1 !STATUS_WORD[22])
      else $error("overflow trap or self clear missing");
   a_flags_load: assert property (INSN_DONE |=>
      STATUS_WORD[21:18] == $past(FLAGS_IN))
      else $error("flags not loaded at instruction end");
   a_trace_trap: assert property (
      TRACE_TRAP == ($past(INSN_DONE) &&
      $past(STATUS_WORD[17]) && !$past(STATUS_WORD[2])))
      else $error("trace trap wrong");
   a_int_admit: assert property (
      INT_ACCEPT == ($past(INT_NMI) ||
      ($past(INT_REQ) && $past(INT_PRIORITY) > $past(STATUS_WORD[16:13]))))
      else $error("interrupt admission wrong");
   a_level_shift: assert property (LEVEL_CHANGE |=>
      STATUS_WORD[12:11] == $past(NEW_LEVEL) &&
      STATUS_WORD[10:9] == $past(STATUS_WORD[12:11]))
      else $error("level change not recorded");
   a_context_bits: assert property (
      SAVE_REGS == STATUS_WORD[8] && START_INITIAL == STATUS_WORD[7])
      else $error("context control outputs off their bits");
endmodule // psesx_status_monitor
////////////////////////////////////////
bind psesx_status psesx_status_monitor u_mon
(
   .SYS_CLK(SYS_CLK),
   .RESET(RESET),
   .INSN_DONE(INSN_DONE),
   .FLAGS_IN(FLAGS_IN),
   .OVF_DETECT(OVF_DETECT),
   .PROCESS_LOAD(PROCESS_LOAD),
   .NEW_LEVEL(NEW_LEVEL),
   .LEVEL_CHANGE(LEVEL_CHANGE),
   .INT_PRIORITY(INT_PRIORITY),
   .INT_REQ(INT_REQ),
   .INT_NMI(INT_NMI),
   .CACHE_FLUSH(CACHE_FLUSH),
   .CACHE_BYPASS(CACHE_BYPASS),
   .FAST_INT_PATH(FAST_INT_PATH),
   .INT_ACCEPT(INT_ACCEPT),
   .TRACE_TRAP(TRACE_TRAP),
   .OVF_TRAP(OVF_TRAP),
   .SAVE_REGS(SAVE_REGS),
   .START_INITIAL(START_INITIAL),
   .STATUS_WORD(STATUS_WORD)
);

// file: verification/test_psesx_status.sv
/*
 Self-checking bench for the status word block over AXI4-Lite.
 Assumes psesx_pkg and psesx_status are compiled first.
*/
`timescale 1ns/10ps
module test_psesx_status;
   logic sys_clk = 1'h0, reset = 1'h1;
   logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
   logic aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0;
   logic ar_valid = 1'h0, r_ready = 1'h0, int_req = 1'h0, int_nmi = 1'h0;
   logic gate_ret = 1'h0;
   logic [31:0] w_data = 32'h0, d;
   logic [1:0] r, new_level = 2'h0;
   logic [6:0] pl = 7'h0;
   logic [12:0] nrm_ev = 13'h0;
   logic [11:0] oth_ev = 12'h0;
   logic [3:0] int_prio = 4'h0;
   psesx_pkg::psesx_flags_t flags_in = 4'ha;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid, cache_flush;
   logic cache_bypass, fast_int, int_accept, trace_trap, ovf_trap;
   logic save_regs, start_init;
   logic [1:0] b_resp, r_resp;
   logic [31:0] r_data, status_word;
   psesx_pkg::psesx_exc_t exc_out;
   logic [15:0] it [6] = '{16'h0101, 16'h0000, 16'hff00, 16'hf011,
      16'h5500, 16'h5601};
   logic [47:0] osub = 48'h643210410210;
   int miscompares = 0;
   int comparisons = 0;
   always #5 sys_clk = ~sys_clk;
   psesx_status DUT
   (
      .SYS_CLK(sys_clk),
      .RESET(reset),
      .S_AWADDR(aw_addr),
      .S_AWVALID(aw_valid),
      .S_AWREADY(aw_ready),
      .S_WDATA(w_data),
      .S_WSTRB(4'hf),
      .S_WVALID(w_valid),
      .S_WREADY(w_ready),
      .S_BRESP(b_resp),
      .S_BVALID(b_valid),
      .S_BREADY(b_ready),
      .S_ARADDR(ar_addr),
      .S_ARVALID(ar_valid),
      .S_ARREADY(ar_ready),
      .S_RDATA(r_data),
      .S_RRESP(r_resp),
      .S_RVALID(r_valid),
      .S_RREADY(r_ready),
      .INSN_START(pl[6]),
      .INSN_DONE(pl[5]),
      .FLAGS_IN(flags_in),
      .OVF_DETECT(pl[4]),
      .NORMAL_EVENTS(nrm_ev),
      .OTHER_EVENTS(oth_ev),
      .CONTEXT_SWITCH(pl[3]),
      .GATE_RETURN(gate_ret),
      .PROCESS_LOAD(pl[2]),
      .SAVE_REGS_IN(1'h1),
      .SAVE_REGS_LOAD(pl[1]),
      .NEW_LEVEL(new_level),
      .LEVEL_CHANGE(pl[0]),
      .INT_PRIORITY(int_prio),
      .INT_REQ(int_req),
      .INT_NMI(int_nmi),
      .CACHE_FLUSH(cache_flush),
      .CACHE_BYPASS(cache_bypass),
      .FAST_INT_PATH(fast_int),
      .INT_ACCEPT(int_accept),
      .TRACE_TRAP(trace_trap),
      .OVF_TRAP(ovf_trap),
      .SAVE_REGS(save_regs),
      .START_INITIAL(start_init),
      .EXC_OUT(exc_out),
      .STATUS_WORD(status_word)
   );
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // every bus and pulse task opens on a fresh edge so no signal is driven twice a step
   // waits for the answer however long; only the watchdog ends a hang
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] rs);
      @(posedge sys_clk);
      aw_addr <= a;
      w_data <= v;
      aw_valid <= 1'h1;
      w_valid <= 1'h1;
      b_ready <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (aw_valid && aw_ready)
            aw_valid <= 1'h0;
         if (w_valid && w_ready)
            w_valid <= 1'h0;
      end
      while (b_valid !== 1'h1);
      rs = b_resp;
      b_ready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] rs);
      @(posedge sys_clk);
      ar_addr <= a;
      ar_valid <= 1'h1;
      r_ready <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (ar_valid && ar_ready)
            ar_valid <= 1'h0;
      end
      while (r_valid !== 1'h1);
      v = r_data;
      rs = r_resp;
      r_ready <= 1'h0;
   endtask
   task automatic rdc(input string n, input logic [7:0] a,
      input logic [31:0] e);
      rd(a, d, r);
      chk(n, e, d);
   endtask
   // pulse bits: start, done, overflow, switch, load, save, level
   task automatic pulse(input logic [6:0] p, input logic [12:0] nv,
      input logic [11:0] ov);
      @(posedge sys_clk);
      pl <= p;
      nrm_ev <= nv;
      oth_ev <= ov;
      @(posedge sys_clk);
      pl <= 7'h0;
      nrm_ev <= 13'h0;
      oth_ev <= 12'h0;
      @(negedge sys_clk);
   endtask
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      #200000;
      miscompares++;
      close_out;
   end
   initial
   begin
      int j;
      logic [1:0] cl;
      logic [3:0] sb;
      repeat (8) @(posedge sys_clk);
      reset <= 1'h0;
      rdc("status reset", 8'h00, 32'h0);
      rd(8'h10, d, r);
      chk("unmapped read", 32'h2, {30'h0, r});
      wr(8'h10, 32'h0, r);
      chk("unmapped write", 32'h2, {30'h0, r});
      wr(8'h00, 32'hffffe7ff, r);
      rdc("status mask", 8'h00, 32'h03ffe6fb);
      chk("ctrl outputs", 32'h3, {30'h0, cache_bypass, fast_int});
      wr(8'h04, 32'h12345678, r);
      rdc("pointer kernel", 8'h04, 32'h12345678);
      wr(8'h00, 32'h00001800, r);
      wr(8'h00, 32'hffffffff, r);
      chk("user write resp", 32'h2, {30'h0, r});
      rdc("status kept", 8'h00, 32'h0000187b);
      wr(8'h04, 32'h0, r);
      chk("pointer resp", 32'h2, {30'h0, r});
      rdc("pointer kept", 8'h04, 32'h12345678);
      pulse(7'h01, 13'h0, 12'h0);
      chk("levels", 32'h3, status_word[12:9]);
      // all 25 event inputs, flags loaded first so a reset shows
      for (int i = 0; i < 25; i++)
      begin
         pulse(7'h20, 13'h0, 12'h0);
         j = i - 13;
         cl = (i < 13) ? 2'h3 : (j < 3) ? 2'h2 : (j < 6) ? 2'h1 : 2'h0;
         sb = (i < 12) ? i[3:0] : (i == 12) ? 4'hf : osub[j*4 +: 4];
         pulse(7'h00, (i < 13) ? 13'h1 << i : 13'h0,
            (i < 13) ? 12'h0 : 12'h1 << j);
         chk("exception", {19'h0, 1'h1, cl, sb, sb, cl},
            {19'h0, exc_out, status_word[6:3], status_word[1:0]});
         if (i < 16)
            chk("flags", (i == 0 || i == 4 || i == 8 || i > 12) ? 4'h0 : 4'ha,
               status_word[21:18]);
      end
      pulse(7'h00, 13'h204, 12'h0);
      chk("priority pick", 32'h2, status_word[6:3]);
      wr(8'h00, 32'h00020000, r);
      pulse(7'h40, 13'h0, 12'h0);
      chk("suppress set", 32'h1, status_word[2]);
      pulse(7'h20, 13'h0, 12'h0);
      chk("trace masked", 32'h0, trace_trap);
      pulse(7'h08, 13'h0, 12'h0);
      chk("suppress clear", 32'h0, status_word[2]);
      pulse(7'h20, 13'h0, 12'h0);
      chk("trace trap", 32'h1, trace_trap);
      pulse(7'h40, 13'h0, 12'h0);
      chk("suppress again", 32'h1, status_word[2]);
      @(posedge sys_clk);
      gate_ret <= 1'h1;
      @(posedge sys_clk);
      gate_ret <= 1'h0;
      @(negedge sys_clk);
      chk("gate clear", 32'h0, status_word[2]);
      wr(8'h00, 32'h00400000, r);
      pulse(7'h10, 13'h0, 12'h0);
      chk("overflow trap", 32'h1, ovf_trap);
      @(negedge sys_clk);
      chk("overflow clear", 32'h0, status_word[22]);
      wr(8'h00, 32'h0, r);
      pulse(7'h04, 13'h0, 12'h0);
      chk("flush", 32'h1, cache_flush);
      wr(8'h00, 32'h02000000, r);
      pulse(7'h04, 13'h0, 12'h0);
      chk("no flush", 32'h0, cache_flush);
      pulse(7'h02, 13'h0, 12'h0);
      chk("save regs", 32'h1, save_regs);
      wr(8'h00, 32'h00000080, r);
      chk("start initial", 32'h1, start_init);
      wr(8'h0c, 32'h0000000f, r);
      chk("ro write resp", 32'h0, {30'h0, r});
      rdc("ctrl view", 8'h0c, 32'h0000000c);
      foreach (it[k])
      begin
         wr(8'h00, {15'h0, it[k][15:12], 13'h0}, r);
         @(posedge sys_clk);
         int_prio <= it[k][11:8];
         int_nmi <= it[k][4];
         int_req <= 1'h1;
         repeat (2) @(negedge sys_clk);
         chk("interrupt", {31'h0, it[k][0]}, {31'h0, int_accept});
         @(posedge sys_clk);
         int_req <= 1'h0;
         int_nmi <= 1'h0;
      end
      close_out;
   end
endmodule // test_psesx_status
